/* fsc_pkg.sv */
// shared constants for the fieldbus sync cycle scheduler
package fsc_pkg;
    localparam int CLK_MHZ          = 50;
    localparam int TICK_US          = 250;
    localparam int TICK_CYC         = TICK_US * CLK_MHZ;
    localparam int WIN_US           = 90;
    localparam int WIN_CYC          = WIN_US * CLK_MHZ;
    localparam int MAX_SYNC_US      = 15000;
    localparam int MAX_SYNC_TICKS   = MAX_SYNC_US / TICK_US;
    localparam int BUF_MGR_COUNT    = 4;
    localparam int BUF_MGR_MAILBOX  = 2;
    localparam int BUF_MGR_CYCLIC   = BUF_MGR_COUNT - BUF_MGR_MAILBOX;

    localparam logic [15:0] IDX_VEL_OFFSET    = 16'h60B1;
    localparam logic [15:0] IDX_PARAM_ZERO    = 16'h3D01;
    localparam logic [15:0] IDX_SYNC_SELECT   = 16'h3D03;
    localparam logic [15:0] IDX_SYNC_TICKS    = 16'h3D10;
    localparam logic [15:0] IDX_STATUS        = 16'h3D11;

    localparam logic [31:0] RST_VEL_OFFSET    = 32'h0000_0000;
    localparam logic [15:0] RST_PARAM_ZERO    = 16'h0000;
    localparam logic [15:0] MAX_PARAM_ZERO    = 16'h7FFF;
    localparam logic [7:0]  RST_SYNC_SELECT   = 8'h01;
    localparam logic [5:0]  RST_SYNC_TICKS    = 6'h04;

    localparam logic [7:0]  SEL_INDEPENDENT   = 8'h00;
    localparam logic [7:0]  SEL_MASTER_SYNC   = 8'h01;
    localparam logic [7:0]  SEL_MASTER_ALWAYS = 8'h02;

    localparam logic [1:0]  MODE_PROFILE      = 2'h0;
    localparam logic [1:0]  MODE_IPM          = 2'h1;
    localparam logic [1:0]  MODE_CSP          = 2'h2;

    localparam int STAT_SYNC_ACTIVE = 0;
    localparam int STAT_IN_WINDOW   = 1;
    localparam int STAT_DRIVE_SYNC  = 2;
endpackage

/* fsc_tick_div.sv */
// cycle divider giving a one-cycle enable every DIV clocks, restartable
`timescale 1ns/100ps
module fsc_tick_div #(
    parameter int DIV = 12500
) (
    input  wire logic clock,
    input  wire logic rstn,
    input  wire logic restart,
    output logic      tick_q
);
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    logic        tick_d;

    always_comb begin
        cnt_d  = cnt_q + 16'h0001;
        tick_d = 1'b0;
        if (restart) begin
            // the caller starts its own cycle on restart; the next tick is a full period on
            cnt_d = 16'h0001;
        end else if (cnt_q >= 16'(DIV - 1)) begin
            cnt_d  = 16'h0000;
            tick_d = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cnt_q  <= 16'h0000;
            tick_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            tick_q <= tick_d;
        end
    end
endmodule // fsc_tick_div

/* fsc_sched.sv */
// cycle scheduler: sync edges, profile/control cycles, 90 us window, objects
//
// Contract
// - drive sync interval is whole ticks, max 15ms
// - position control at sync interval, else each tick
// - synced profile mode: profile cycle on sync edge
// - unsynced: profile cycle every 250 us
// - interpolated mode: internal position command every tick
// - interpolation cycle aligned to sync edge
// - commands cached in first 90 us of cycle
// - feedback held, published in next cycle window
// - profile-rate feedback from last control cycle
// - process data copied at profile cycle window
// - drive parameters written each control cycle window
// - four buffer managers, two mailbox, two cyclic
// - sync master select 0..2, default 1
// - parameter zero shortcut 0..32767, default 0
// - velocity offset signed 32, default 0
// - speed and current tasks locked to network sync
// - csp mode uses velocity offset as feed-forward
`timescale 1ns/100ps
module fsc_sched
    import fsc_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC,
    parameter int WIN_CYCLES  = WIN_CYC
) (
    input  wire logic                clock,
    input  wire logic                rstn,
    input  wire logic                net_sync,
    input  wire logic                dc_enable,
    input  wire logic                fieldbus_sync_ok,
    input  wire logic [1:0]          op_mode,
    input  wire logic signed [31:0]  cmd_pos,
    input  wire logic signed [31:0]  fb_val,
    input  wire logic                obj_wr,
    input  wire logic                obj_rd,
    input  wire logic [15:0]         obj_index,
    input  wire logic [31:0]         obj_wdata,
    output logic [31:0]              obj_rdata_q,
    output logic                     obj_ack_q,
    output logic                     drive_sync_q,
    output logic                     drive_sync_en_q,
    output logic                     ctl_start_q,
    output logic                     prof_start_q,
    output logic                     pos_go_q,
    output logic                     in_window_q,
    output logic [BUF_MGR_CYCLIC-1:0] pdo_copy_q,
    output logic                     param_wr_q,
    output logic signed [31:0]       cmd_cache_q,
    output logic signed [31:0]       pos_cmd_q,
    output logic signed [31:0]       fb_ctl_q,
    output logic signed [31:0]       fb_pub_q,
    output logic signed [31:0]       vel_ff_q,
    output logic [15:0]              param_zero_q
);
    // pin synchronisers; third net flop only feeds the edge detector
    logic [1:0] net_s_q, dc_s_q, fok_s_q;
    logic       net_d3_q;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            net_s_q  <= 2'h0;
            dc_s_q   <= 2'h0;
            fok_s_q  <= 2'h0;
            net_d3_q <= 1'b0;
        end else begin
            net_s_q  <= {net_s_q[0], net_sync};
            dc_s_q   <= {dc_s_q[0], dc_enable};
            fok_s_q  <= {fok_s_q[0], fieldbus_sync_ok};
            net_d3_q <= net_s_q[1];
        end
    end

    // object registers
    logic signed [31:0] vel_offset_q, vel_offset_d;
    logic [7:0]         sync_sel_q, sync_sel_d;
    logic [15:0]        param_zero_d;
    logic [5:0]         sync_ticks_q, sync_ticks_d;
    logic [31:0]        obj_rdata_d;
    logic               obj_ack_d;

    always_comb begin
        vel_offset_d = vel_offset_q;
        sync_sel_d   = sync_sel_q;
        param_zero_d = param_zero_q;
        sync_ticks_d = sync_ticks_q;
        obj_rdata_d  = 32'h0000_0000;
        obj_ack_d    = obj_wr | obj_rd;
        if (obj_wr) begin
            case (obj_index)
                IDX_VEL_OFFSET: vel_offset_d = obj_wdata;
                IDX_PARAM_ZERO: begin
                    if (obj_wdata <= 32'(MAX_PARAM_ZERO))
                        param_zero_d = obj_wdata[15:0];
                end
                IDX_SYNC_SELECT: begin
                    if (obj_wdata <= 32'(SEL_MASTER_ALWAYS))
                        sync_sel_d = obj_wdata[7:0];
                end
                IDX_SYNC_TICKS: begin
                    // out-of-range intervals are refused so the wave never passes 15 ms
                    if (obj_wdata != 32'h0 && obj_wdata <= 32'(MAX_SYNC_TICKS))
                        sync_ticks_d = obj_wdata[5:0];
                end
                default: ;
            endcase
        end else if (obj_rd) begin
            case (obj_index)
                IDX_VEL_OFFSET:  obj_rdata_d = vel_offset_q;
                IDX_PARAM_ZERO:  obj_rdata_d = {16'h0000, param_zero_q};
                IDX_SYNC_SELECT: obj_rdata_d = {24'h000000, sync_sel_q};
                IDX_SYNC_TICKS:  obj_rdata_d = {26'h0000000, sync_ticks_q};
                IDX_STATUS: begin
                    obj_rdata_d[STAT_SYNC_ACTIVE] = drive_sync_en_q;
                    obj_rdata_d[STAT_IN_WINDOW]   = in_window_q;
                    obj_rdata_d[STAT_DRIVE_SYNC]  = drive_sync_q;
                end
                default:         obj_rdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            vel_offset_q <= RST_VEL_OFFSET;
            sync_sel_q   <= RST_SYNC_SELECT;
            param_zero_q <= RST_PARAM_ZERO;
            sync_ticks_q <= RST_SYNC_TICKS;
            obj_rdata_q  <= 32'h0000_0000;
            obj_ack_q    <= 1'b0;
        end else begin
            vel_offset_q <= vel_offset_d;
            sync_sel_q   <= sync_sel_d;
            param_zero_q <= param_zero_d;
            sync_ticks_q <= sync_ticks_d;
            obj_rdata_q  <= obj_rdata_d;
            obj_ack_q    <= obj_ack_d;
        end
    end

    // mastership decision and cycle timing
    logic       sync_act;
    logic       net_edge;
    logic       tick;
    logic       restart;
    logic [5:0] intv_q, intv_d;
    logic       ctl_d, prof_d, pos_d, dsync_d, dsen_d;

    assign sync_act = dc_s_q[1] && ((sync_sel_q == SEL_MASTER_ALWAYS) ||
                      ((sync_sel_q == SEL_MASTER_SYNC) && fok_s_q[1]));
    assign net_edge = net_s_q[1] & ~net_d3_q;
    assign restart  = sync_act & net_edge;

    fsc_tick_div #(
        .DIV     (TICK_CYCLES)
    ) u_tick (
        .clock   (clock),
        .rstn    (rstn),
        .restart (restart),
        .tick_q  (tick)
    );

    always_comb begin
        intv_d  = intv_q;
        ctl_d   = 1'b0;
        prof_d  = 1'b0;
        pos_d   = 1'b0;
        dsync_d = drive_sync_q;
        dsen_d  = sync_act;
        if (!sync_act) begin
            // fallback: control, profile and position cycles run on the free 250 us tick; the drive sync wave holds
            intv_d = 6'h00;
            ctl_d  = tick;
            prof_d = tick;
            pos_d  = tick;
        end else if (net_edge) begin
            // network edge re-phases the control loop and the interval
            intv_d  = 6'h00;
            ctl_d   = 1'b1;
            prof_d  = 1'b1;
            pos_d   = 1'b1;
            dsync_d = ~drive_sync_q;
        end else if (tick) begin
            ctl_d = 1'b1;
            if (intv_q + 6'h01 >= sync_ticks_q) begin
                // flywheel edge keeps the wave on whole ticks if the network edge is late
                intv_d  = 6'h00;
                prof_d  = 1'b1;
                pos_d   = 1'b1;
                dsync_d = ~drive_sync_q;
            end else begin
                intv_d = intv_q + 6'h01;
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            intv_q          <= 6'h00;
            ctl_start_q     <= 1'b0;
            prof_start_q    <= 1'b0;
            pos_go_q        <= 1'b0;
            drive_sync_q    <= 1'b0;
            drive_sync_en_q <= 1'b0;
        end else begin
            intv_q          <= intv_d;
            ctl_start_q     <= ctl_d;
            prof_start_q    <= prof_d;
            pos_go_q        <= pos_d;
            drive_sync_q    <= dsync_d;
            drive_sync_en_q <= dsen_d;
        end
    end

    // 90 us data window at the head of every control cycle
    logic [15:0]                win_q, win_d;
    logic                       inw_d, pwr_d;
    logic [BUF_MGR_CYCLIC-1:0]  pdo_d;

    always_comb begin
        win_d = (win_q != 16'h0000) ? win_q - 16'h0001 : 16'h0000;
        if (ctl_d)
            win_d = 16'(WIN_CYCLES - 1);
        inw_d = ctl_d || (win_q != 16'h0000);
        pwr_d = ctl_d;
        // only the cyclic managers move per cycle; mailbox ones are event driven
        pdo_d = prof_d ? {BUF_MGR_CYCLIC{1'b1}} : '0;
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            win_q       <= 16'h0000;
            in_window_q <= 1'b0;
            param_wr_q  <= 1'b0;
            pdo_copy_q  <= '0;
        end else begin
            win_q       <= win_d;
            in_window_q <= inw_d;
            param_wr_q  <= pwr_d;
            pdo_copy_q  <= pdo_d;
        end
    end

    // command cache, interpolation, feedback hold, feed-forward
    logic signed [31:0] tgt_q, tgt_d, step_q, step_d;
    logic signed [31:0] cmd_d, pos_cmd_d, fb_ctl_d, fb_pub_d, vel_ff_d;
    logic signed [31:0] nsub;

    assign nsub = sync_act ? $signed({26'h0000000, sync_ticks_q}) : 32'sd1;

    always_comb begin
        tgt_d     = tgt_q;
        step_d    = step_q;
        cmd_d     = cmd_cache_q;
        pos_cmd_d = pos_cmd_q;
        fb_ctl_d  = fb_ctl_q;
        fb_pub_d  = fb_pub_q;
        vel_ff_d  = (op_mode == MODE_CSP) ? vel_offset_q : 32'sd0;
        if (prof_d) begin
            cmd_d    = cmd_pos;
            fb_pub_d = fb_val;
        end
        if (ctl_d)
            fb_ctl_d = fb_val;
        if (op_mode == MODE_IPM) begin
            if (prof_d) begin
                // one command of delay: restart from the previous target exactly
                tgt_d     = cmd_pos;
                pos_cmd_d = tgt_q;
                step_d    = (cmd_pos - tgt_q) / nsub;
            end else if (ctl_d) begin
                pos_cmd_d = pos_cmd_q + step_q;
            end
        end else if (prof_d) begin
            tgt_d     = cmd_pos;
            pos_cmd_d = cmd_pos;
            step_d    = 32'sd0;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            tgt_q       <= 32'sd0;
            step_q      <= 32'sd0;
            cmd_cache_q <= 32'sd0;
            pos_cmd_q   <= 32'sd0;
            fb_ctl_q    <= 32'sd0;
            fb_pub_q    <= 32'sd0;
            vel_ff_q    <= 32'sd0;
        end else begin
            tgt_q       <= tgt_d;
            step_q      <= step_d;
            cmd_cache_q <= cmd_d;
            pos_cmd_q   <= pos_cmd_d;
            fb_ctl_q    <= fb_ctl_d;
            fb_pub_q    <= fb_pub_d;
            vel_ff_q    <= vel_ff_d;
        end
    end

    // checks
    logic [6:0] edge_gap_q;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn)
            edge_gap_q <= 7'h00;
        else if (drive_sync_q != dsync_d || !sync_act)
            edge_gap_q <= 7'h00;
        else if (tick)
            edge_gap_q <= edge_gap_q + 7'h01;
    end

    // mode of the cycle that launched the pulse, so a mode change cannot trip these
    sequence s_prof_ipm;
        prof_start_q && $past(op_mode) == MODE_IPM;
    endsequence
    sequence s_ctl_only;
        ctl_start_q && !prof_start_q && $past(op_mode) == MODE_IPM;
    endsequence

    a_interval_max: assert property (@(posedge clock) disable iff (!rstn)
        edge_gap_q <= 7'(MAX_SYNC_TICKS)) else $error("sync interval too long");
    a_fallback_tick: assert property (@(posedge clock) disable iff (!rstn)
        (!sync_act && tick) |=> (prof_start_q && pos_go_q && ctl_start_q))
        else $error("fallback tick missed a cycle");
    a_prof_on_ctl: assert property (@(posedge clock) disable iff (!rstn)
        prof_start_q |-> (ctl_start_q && pos_go_q)) else $error("profile start off loop");
    a_window_open: assert property (@(posedge clock) disable iff (!rstn)
        ctl_start_q |-> in_window_q ##1 in_window_q [*3])
        else $error("window not open at cycle start");
    a_pdo_in_window: assert property (@(posedge clock) disable iff (!rstn)
        (pdo_copy_q != '0) |-> (in_window_q && prof_start_q))
        else $error("pdo copy outside window");
    a_param_each: assert property (@(posedge clock) disable iff (!rstn)
        ctl_start_q == param_wr_q) else $error("parameter write not each cycle");
    a_sel_range: assert property (@(posedge clock) disable iff (!rstn)
        sync_sel_q <= SEL_MASTER_ALWAYS) else $error("sync select out of range");
    a_shortcut_range: assert property (@(posedge clock) disable iff (!rstn)
        param_zero_q <= MAX_PARAM_ZERO) else $error("shortcut out of range");
    a_vel_ff_csp: assert property (@(posedge clock) disable iff (!rstn)
        (op_mode == MODE_CSP) |=> vel_ff_q == $past(vel_offset_q))
        else $error("feed-forward not velocity offset");
    a_fb_publish: assert property (@(posedge clock) disable iff (!rstn)
        prof_d |=> fb_pub_q == $past(fb_val)) else $error("feedback not published");
    a_ipm_step: assert property (@(posedge clock) disable iff (!rstn)
        s_ctl_only |-> pos_cmd_q == $past(pos_cmd_q) + $past(step_q))
        else $error("interpolation step wrong");
    a_ipm_align: assert property (@(posedge clock) disable iff (!rstn)
        s_prof_ipm |-> pos_cmd_q == $past(tgt_q)) else $error("interpolation not aligned");
    a_sync_lock: assert property (@(posedge clock) disable iff (!rstn)
        (sync_act && net_edge) |=> (ctl_start_q && drive_sync_en_q))
        else $error("loop not locked to network edge");
endmodule // fsc_sched

/* fsc_net_master.sv */
// fieldbus master model: network sync square wave and cyclic position command
`timescale 1ns/100ps
module fsc_net_master #(
    parameter int PERIOD = 80,
    parameter int STEP   = 64
) (
    input  wire logic         clock,
    input  wire logic         rstn,
    input  wire logic         run,
    output logic              net_sync,
    output logic signed [31:0] cmd_pos
);
    int cnt;

    // pin rests low when the master is not producing sync
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            net_sync <= 1'b0;
            cnt <= 0;
            cmd_pos <= 32'sh0;
        end else if (!run) begin
            net_sync <= 1'b0;
            cnt <= 0;
        end else begin
            cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
            net_sync <= (cnt < PERIOD / 2);
            // one new command per interpolation cycle, with the rising edge
            if (cnt == 0) begin
                cmd_pos <= cmd_pos + STEP;
            end
        end
    end
endmodule // fsc_net_master

/* fsc_sched_tb.sv */
// self-checking testbench for the fieldbus sync cycle scheduler
`timescale 1ns/100ps
module fsc_sched_tb
    import fsc_pkg::*;
;
    localparam int TK = 20;
    localparam int WN = 8;
    typedef struct {logic wr; logic [15:0] idx; logic [31:0] wd; logic [31:0] exp;} fsc_row_t;

    logic clock = 1'b0, rstn = 1'b0, dc_enable = 1'b0, fieldbus_sync_ok = 1'b1, run = 1'b0;
    logic obj_wr = 1'b0, obj_rd = 1'b0, net_sync, ns_prev, ds_prev;
    logic [1:0]  op_mode = MODE_PROFILE;
    logic [15:0] obj_index = 16'h0000;
    logic [31:0] obj_wdata = 32'h0000_0000, obj_rdata_q, rd;
    logic signed [31:0] cmd_pos, fb_val = 32'sh0000_022B;
    logic obj_ack_q, drive_sync_q, drive_sync_en_q, ctl_start_q, prof_start_q, pos_go_q;
    logic in_window_q, param_wr_q;
    logic [BUF_MGR_CYCLIC-1:0] pdo_copy_q, pdo_seen;
    logic signed [31:0] cmd_cache_q, pos_cmd_q, fb_ctl_q, fb_pub_q, vel_ff_q;
    logic signed [31:0] last_cache, prev_cache, pos_at_prof;
    logic [15:0] param_zero_q;
    int cyc, ctl_last, prof_last, ctl_gap, prof_gap, win_run, win_len, rise_cyc, sync_lat;
    int pw_bad, fb_bad, ds_last, ds_gap, n_mismatch, samples_checked;

    fsc_row_t rows [15] = '{
        '{1'b0, IDX_VEL_OFFSET, 32'h0, 32'h0}, '{1'b0, IDX_PARAM_ZERO, 32'h0, 32'h0},
        '{1'b0, IDX_SYNC_SELECT, 32'h0, 32'h1}, '{1'b0, IDX_SYNC_TICKS, 32'h0, 32'h4},
        '{1'b1, IDX_PARAM_ZERO, 32'h7FFF, 32'h0}, '{1'b0, IDX_PARAM_ZERO, 32'h0, 32'h7FFF},
        '{1'b1, IDX_PARAM_ZERO, 32'h8000, 32'h0}, '{1'b0, IDX_PARAM_ZERO, 32'h0, 32'h7FFF},
        '{1'b1, IDX_SYNC_SELECT, 32'h3, 32'h0}, '{1'b0, IDX_SYNC_SELECT, 32'h0, 32'h1},
        '{1'b1, IDX_SYNC_SELECT, 32'h2, 32'h0}, '{1'b0, IDX_SYNC_SELECT, 32'h0, 32'h2},
        '{1'b1, IDX_VEL_OFFSET, 32'hFFFF_FFF0, 32'h0},
        '{1'b0, IDX_VEL_OFFSET, 32'h0, 32'hFFFF_FFF0}, '{1'b0, 16'h1234, 32'h0, 32'h0}};

    always #10 clock = ~clock;

    fsc_net_master #(.PERIOD(4 * TK), .STEP(64)) i_master (
        .clock(clock), .rstn(rstn), .run(run), .net_sync(net_sync), .cmd_pos(cmd_pos));

    fsc_sched #(.TICK_CYCLES(TK), .WIN_CYCLES(WN)) i_dut (
        .clock(clock), .rstn(rstn), .net_sync(net_sync), .dc_enable(dc_enable),
        .fieldbus_sync_ok(fieldbus_sync_ok), .op_mode(op_mode), .cmd_pos(cmd_pos),
        .fb_val(fb_val), .obj_wr(obj_wr), .obj_rd(obj_rd), .obj_index(obj_index),
        .obj_wdata(obj_wdata), .obj_rdata_q(obj_rdata_q), .obj_ack_q(obj_ack_q),
        .drive_sync_q(drive_sync_q), .drive_sync_en_q(drive_sync_en_q),
        .ctl_start_q(ctl_start_q), .prof_start_q(prof_start_q), .pos_go_q(pos_go_q),
        .in_window_q(in_window_q), .pdo_copy_q(pdo_copy_q), .param_wr_q(param_wr_q),
        .cmd_cache_q(cmd_cache_q), .pos_cmd_q(pos_cmd_q), .fb_ctl_q(fb_ctl_q),
        .fb_pub_q(fb_pub_q), .vel_ff_q(vel_ff_q), .param_zero_q(param_zero_q));

    // sampled mid-cycle so pulses and spacings are read settled
    always @(negedge clock) begin
        cyc++;
        if (net_sync === 1'b1 && ns_prev !== 1'b1) begin
            rise_cyc = cyc;
        end
        ns_prev = net_sync;
        if (param_wr_q !== ctl_start_q || pos_go_q !== prof_start_q) begin
            pw_bad++;
        end
        if (ctl_start_q === 1'b1) begin
            ctl_gap = cyc - ctl_last;
            ctl_last = cyc;
            if (fb_ctl_q !== cyc - 1) begin
                fb_bad++;
            end
            if (prof_start_q !== 1'b1 && fb_pub_q === cyc - 1) begin
                fb_bad++;
            end
        end
        if (drive_sync_q !== ds_prev) begin
            ds_gap = cyc - ds_last;
            ds_last = cyc;
        end
        ds_prev = drive_sync_q;
        if (prof_start_q === 1'b1) begin
            if (fb_pub_q !== cyc - 1) begin
                fb_bad++;
            end
            prof_gap = cyc - prof_last;
            prof_last = cyc;
            sync_lat = cyc - rise_cyc;
            pdo_seen = pdo_copy_q;
            prev_cache = last_cache;
            last_cache = cmd_cache_q;
            pos_at_prof = pos_cmd_q;
        end
        if (in_window_q === 1'b1) begin
            win_run++;
        end else if (win_run != 0) begin
            win_len = win_run;
            win_run = 0;
        end
        // feedback moves every cycle so a capture in the wrong cycle shows
        fb_val = cyc;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic obj(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
                       output logic [31:0] rdv);
        int k;
        @(negedge clock);
        obj_wr = wr;
        obj_rd = !wr;
        obj_index = idx;
        obj_wdata = wd;
        @(negedge clock);
        obj_wr = 1'b0;
        obj_rd = 1'b0;
        for (k = 0; k < 4 && obj_ack_q !== 1'b1; k++) begin
            @(negedge clock);
        end
        if (obj_ack_q !== 1'b1) begin
            n_mismatch++;
            test_done();
        end
        rdv = obj_rdata_q;
    endtask

    initial begin
        repeat (5000) @(posedge clock);
        n_mismatch++;
        test_done();
    end

    initial begin
        repeat (12) @(negedge clock);
        rstn = 1'b1;
        repeat (2) @(negedge clock);
        foreach (rows[i]) begin
            obj(rows[i].wr, rows[i].idx, rows[i].wd, rd);
            check($sformatf("object row %0d", i), rd, rows[i].exp);
        end
        check("shortcut port", param_zero_q, 16'h7FFF);
        // free-running tick, cyclic position mode
        op_mode = MODE_CSP;
        repeat (5 * TK) @(negedge clock);
        check("ctl gap", ctl_gap, TK);
        check("prof gap", prof_gap, TK);
        check("window", win_len, WN);
        check("pdo copy", pdo_seen, 2'h3);
        check("fb publish", fb_pub_q, 32'h0000_0084);
        check("fb control", fb_ctl_q, 32'h0000_0084);
        check("vel ff csp", vel_ff_q, 32'hFFFF_FFF0);
        check("sync en off", drive_sync_en_q, 1'b0);
        // network sync, select 2, interpolated mode
        op_mode = MODE_IPM;
        dc_enable = 1'b1;
        run = 1'b1;
        repeat (24 * TK) @(negedge clock);
        check("sync ctl gap", ctl_gap, TK);
        check("sync prof gap", prof_gap, 4 * TK);
        check("sync latency", sync_lat, 3);
        check("sync en", drive_sync_en_q, 1'b1);
        check("interp start", pos_at_prof, prev_cache);
        check("vel ff ipm", vel_ff_q, 32'h0);
        check("interp step", pos_cmd_q, 32'h0000_0170);
        check("cmd cache", cmd_cache_q, 32'h0000_0180);
        check("drive sync gap", ds_gap, 4 * TK);
        check("fb per cycle", fb_bad, 0);
        // select 1 without fieldbus sync falls back to the tick
        fieldbus_sync_ok = 1'b0;
        obj(1'b1, IDX_SYNC_SELECT, 32'h1, rd);
        repeat (16 * TK) @(negedge clock);
        check("fallback en", drive_sync_en_q, 1'b0);
        check("fallback gap", prof_gap, TK);
        fieldbus_sync_ok = 1'b1;
        repeat (16 * TK) @(negedge clock);
        check("select 1 en", drive_sync_en_q, 1'b1);
        check("select 1 gap", prof_gap, 4 * TK);
        check("param pulses", pw_bad, 0);
        check("drive sync gap 1", ds_gap, 4 * TK);
        check("fb per cycle 1", fb_bad, 0);
        obj(1'b0, IDX_STATUS, 32'h0, rd);
        check("status", rd, 32'h0000_0005);
        @(negedge clock);
        // reset in mid-run
        rstn = 1'b0;
        @(negedge clock);
        check("reset en", drive_sync_en_q, 1'b0);
        check("reset wave", drive_sync_q, 1'b0);
        check("reset vel ff", vel_ff_q, 32'h0);
        rstn = 1'b1;
        run = 1'b0;
        obj(1'b0, IDX_SYNC_SELECT, 32'h0, rd);
        check("reset select", rd, 32'h1);
        test_done();
    end
endmodule // fsc_sched_tb
